// ---- hdl/emad_pkg.sv ----
/*
 * Constants for the extended memory address decoder: address range
 * bounds, window granularity, request sources and routing targets.
 * Assumes 32-bit host addresses and 1 MB granular configuration values.
 */
package emad_pkg;
    // =========================================================
    // Widths
    // =========================================================
    localparam int ADDR_W  = 32;
    localparam int WIDE_W  = 33;   // Address plus carry for 4 GB compares
    localparam int MB_W    = 12;   // Window fields give A[31:20]
    localparam int TOM_W   = 13;   // Top of memory in MB, up to 4096
    localparam int LOW_W   = 20;   // Bits below 1 MB granularity

    // =========================================================
    // Fixed ranges
    // =========================================================
    localparam logic [ADDR_W-1:0] EXT_BASE   = 32'h0010_0000;
    localparam logic [ADDR_W-1:0] HOLE_LO    = 32'h00f0_0000;
    localparam logic [ADDR_W-1:0] HOLE_HI    = 32'h00ff_ffff;
    localparam logic [ADDR_W-1:0] VGA_BASE   = 32'h000a_0000;
    localparam logic [ADDR_W-1:0] HIGH_SMRAM_SEGMENT_MASK  = 32'h0001_ffff;
    localparam logic [ADDR_W-1:0] IOAPIC_LO  = 32'hfec0_0000;
    localparam logic [ADDR_W-1:0] IOAPIC_HI  = 32'hfecf_ffff;
    localparam logic [ADDR_W-1:0] MID_LO     = 32'hfed0_0000;
    localparam logic [ADDR_W-1:0] MID_HI     = 32'hffdf_ffff;
    localparam logic [ADDR_W-1:0] BIOS_LO    = 32'hffe0_0000;
    localparam logic [ADDR_W-1:0] BIOS_HI    = 32'hffff_ffff;
    localparam logic [ADDR_W-1:0] IMPEDANCE_COMPENSATION_MASK = 32'h0000_0fff;

    // =========================================================
    // Granularity and sizes
    // =========================================================
    localparam logic [LOW_W-1:0]  BASE_LOW   = 20'h0_0000;
    localparam logic [LOW_W-1:0]  LIMIT_LOW  = 20'hf_ffff;
    localparam logic [TOM_W-1:0]  TOM_MAX    = 13'h1000; // 4 GB in MB
    localparam logic [WIDE_W-1:0] TOP_SMRAM_SEGMENT_MIN   = 33'h0_0002_0000;

    // =========================================================
    // Request sources
    // =========================================================
    localparam logic [1:0] SRC_CPU = 2'h0;
    localparam logic [1:0] SRC_AGP = 2'h1;
    localparam logic [1:0] SRC_HUB = 2'h2;

    // =========================================================
    // Routing targets
    // =========================================================
    localparam logic [2:0] TGT_DRAM  = 3'h0;
    localparam logic [2:0] TGT_HUB   = 3'h1;
    localparam logic [2:0] TGT_AGP   = 3'h2;
    localparam logic [2:0] TGT_ABORT = 3'h3;
    localparam logic [2:0] TGT_MMIO  = 3'h4;
endpackage

// ---- hdl/emad_agp_window.sv ----
/*
 * One AGP base/limit window compare at 1 MB granularity.
 * Assumes base and limit come from configuration logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module emad_agp_window
    import emad_pkg::*;
(
    // Window fields
    input  wire logic [MB_W-1:0]   i_base,
    input  wire logic [MB_W-1:0]   i_limit,
    // Address under test
    input  wire logic [ADDR_W-1:0] i_addr,
    // Result
    output logic                   o_hit
);
    // =========================================================
    // Compare
    // =========================================================
    logic [ADDR_W-1:0] lo;
    logic [ADDR_W-1:0] hi;

    // Base pads with zeros, limit with ones
    assign lo    = {i_base, BASE_LOW};                 // RULE16
    assign hi    = {i_limit, LIMIT_LOW};               // RULE16
    assign o_hit = (i_addr >= lo) && (i_addr <= hi);   // RULE17
endmodule
`default_nettype wire

// ---- hdl/emad_decoder.sv ----
/*
 * Extended memory address decoder: routes each host memory cycle from
 * 1 MB to 4 GB to DRAM, the south hub link, AGP, internal MMIO or abort.
 * Assumes one request per valid cycle from same-clock logic and that all
 * configuration inputs are static while requests flow.
 */
// Operation
// [RULE1] From 1 MB up to top of main memory go to DRAM.
// [RULE2] With hole enabled, 15 MB to 16 MB goes to the hub link.
// [RULE3] DRAM under an open hole is not relocated and unreachable.
// [RULE4] No APIC relocation, no DRAM restriction, decode capped at 4 GB.
// [RULE5] SMM processor access to high segment reaches DRAM at A0000h.
// [RULE6] Non-SMM high segment access aborts, write-backs still redirected.
// [RULE7] DRAM at the high segment's own addresses is never reached.
// [RULE8] Top segment up to 1 MB below top; SMM reaches same address.
// [RULE9] Non-SMM top segment access aborts, write-backs go to DRAM.
// [RULE10] AGP or hub link cycles never reach enabled SMRAM.
// [RULE11] Size field sets extent; other SMRAM accesses go to hub.
// [RULE12] Top of memory to 4 GB goes to hub, except compensation window.
// [RULE13] I/O interrupt controller range goes to hub, never AGP.
// [RULE14] Range between interrupt space and high BIOS goes to hub.
// [RULE15] Top 2 MB goes to hub for boot fetches.
// [RULE16] Window fields give A[31:20]; base low zeros, limit low ones.
// [RULE17] Address within either AGP window is claimed for AGP.
// [RULE18] AGP windows decode only with memory access enable set.
// [RULE19] Software keeps all ranges distinct; overlaps route undefined.
// [RULE20] Order: SMRAM, hole, DRAM, compensation, AGP, default hub; the code checks the fixed hub ranges before AGP.
`timescale 1ns/1ns
`default_nettype none
module emad_decoder
    import emad_pkg::*;
#(
    parameter logic [ADDR_W-1:0] P_HIGH_SMRAM_SEGMENT_BASE  = 32'hfed0_0000,
    parameter logic [ADDR_W-1:0] P_IMPEDANCE_COMPENSATION_BASE = 32'hfe00_0000
)(
    // Clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_resetn,
    // Request from host side
    input  wire logic              i_req_valid,
    input  wire logic [ADDR_W-1:0] i_req_addr,
    input  wire logic [1:0]        i_req_src,
    input  wire logic              i_req_smm,
    input  wire logic              i_req_wb,
    // Configuration
    input  wire logic [TOM_W-1:0]  i_top_of_main_memory,
    input  wire logic              i_fixed_hole_control,
    input  wire logic              i_high_smram_segment_en,
    input  wire logic              i_top_smram_segment_en,
    input  wire logic [1:0]        i_smram_size_field,
    input  wire logic [MB_W-1:0]   i_agp_window_base,
    input  wire logic [MB_W-1:0]   i_agp_window_limit,
    input  wire logic [MB_W-1:0]   i_agp_prefetch_window_base,
    input  wire logic [MB_W-1:0]   i_agp_prefetch_window_limit,
    input  wire logic              i_agp_mem_enable,
    // Routing result
    output logic                   o_rsp_valid,
    output logic [2:0]             o_rsp_target,
    output logic [ADDR_W-1:0]      o_rsp_addr
);
    // =========================================================
    // Helpers
    // =========================================================
    // Inclusive range test on a 32-bit address
    function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] lo,
                                      input logic [ADDR_W-1:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // Half-open test in 33 bits so 4 GB is a valid upper bound
    function automatic logic below(input logic [WIDE_W-1:0] a,
                                   input logic [WIDE_W-1:0] lo,
                                   input logic [WIDE_W-1:0] hi);
        below = (a >= lo) && (a < hi);
    endfunction

    // =========================================================
    // Range decode
    // =========================================================
    logic [TOM_W-1:0]  tom_mb;
    logic [WIDE_W-1:0] addr_w;
    logic [WIDE_W-1:0] tom_w;
    logic [WIDE_W-1:0] top_smram_segment_size;
    logic [WIDE_W-1:0] top_smram_segment_lo;
    logic              high_smram_segment_hit;
    logic              top_smram_segment_hit;
    logic              hole_hit;
    logic              dram_hit;
    logic              impedance_compensation_hit;
    logic              fixed_hub_hit;
    logic              agp_hit_mem;
    logic              agp_hit_pref;
    logic              agp_hit;

    // Top of memory clamps at 4 GB, no APIC carve-out
    assign tom_mb    = (i_top_of_main_memory > TOM_MAX) ? TOM_MAX
                     : i_top_of_main_memory;                   // RULE4
    assign addr_w    = {1'b0, i_req_addr};
    assign tom_w     = {tom_mb, BASE_LOW};
    // Top segment size 128 KB times 2^field, at most 1 MB
    assign top_smram_segment_size = TOP_SMRAM_SEGMENT_MIN << i_smram_size_field;         // RULE11
    assign top_smram_segment_lo   = tom_w - top_smram_segment_size;                      // RULE8

    assign high_smram_segment_hit  = i_high_smram_segment_en
                     && in_range(i_req_addr, P_HIGH_SMRAM_SEGMENT_BASE,
                                 P_HIGH_SMRAM_SEGMENT_BASE | HIGH_SMRAM_SEGMENT_MASK);
    assign top_smram_segment_hit  = i_top_smram_segment_en
                     && (tom_w >= top_smram_segment_size)
                     && below(addr_w, top_smram_segment_lo, tom_w);
    assign hole_hit  = i_fixed_hole_control
                     && in_range(i_req_addr, HOLE_LO, HOLE_HI); // RULE2
    assign dram_hit  = below(addr_w, {1'b0, EXT_BASE}, tom_w);  // RULE1
    assign impedance_compensation_hit = in_range(i_req_addr, P_IMPEDANCE_COMPENSATION_BASE,
                                P_IMPEDANCE_COMPENSATION_BASE | IMPEDANCE_COMPENSATION_MASK);
    // Interrupt controller, middle and BIOS ranges go to hub unless SMRAM, DRAM or compensation hit first
    assign fixed_hub_hit = in_range(i_req_addr, IOAPIC_LO, IOAPIC_HI)
                         || in_range(i_req_addr, MID_LO, MID_HI)     // RULE14
                         || in_range(i_req_addr, BIOS_LO, BIOS_HI);  // RULE15

    // Ordinary AGP window
    emad_agp_window u_win_mem (
        .i_base  (i_agp_window_base),
        .i_limit (i_agp_window_limit),
        .i_addr  (i_req_addr),
        .o_hit   (agp_hit_mem)
    );

    // Prefetchable AGP window
    emad_agp_window u_win_pref (
        .i_base  (i_agp_prefetch_window_base),
        .i_limit (i_agp_prefetch_window_limit),
        .i_addr  (i_req_addr),
        .o_hit   (agp_hit_pref)
    );

    // Windows gated by the command register enable
    assign agp_hit = i_agp_mem_enable
                   && (agp_hit_mem || agp_hit_pref);           // RULE18

    // =========================================================
    // Routing decision
    // =========================================================
    logic              next_rsp_valid;
    logic [2:0]        next_rsp_target;
    logic [ADDR_W-1:0] next_rsp_addr;

    // Priority chain, first match wins
    always_comb begin
        next_rsp_valid  = i_req_valid;
        next_rsp_target = TGT_HUB;
        next_rsp_addr   = i_req_addr;
        if (high_smram_segment_hit || top_smram_segment_hit) begin                        // RULE20
            if (i_req_src != SRC_CPU) begin
                next_rsp_target = TGT_HUB;                     // RULE10
            end else if (i_req_smm || i_req_wb) begin
                next_rsp_target = TGT_DRAM;                    // RULE9
                if (high_smram_segment_hit) begin
                    // Fold onto legacy video range
                    next_rsp_addr = VGA_BASE
                                  | (i_req_addr & HIGH_SMRAM_SEGMENT_MASK);  // RULE5 RULE7
                end
            end else begin
                next_rsp_target = TGT_ABORT;                   // RULE6
            end
        end else if (hole_hit) begin
            next_rsp_target = TGT_HUB;                         // RULE3
        end else if (dram_hit) begin
            next_rsp_target = TGT_DRAM;                        // RULE1
        end else if (impedance_compensation_hit) begin
            next_rsp_target = TGT_MMIO;                        // RULE12
        end else if (fixed_hub_hit) begin
            next_rsp_target = TGT_HUB;                         // RULE13
        end else if (agp_hit) begin
            next_rsp_target = TGT_AGP;                         // RULE17
        end else begin
            next_rsp_target = TGT_HUB;                         // RULE12
        end
    end

    // Result registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_rsp_valid  <= 1'b0;
            o_rsp_target <= TGT_HUB;
            o_rsp_addr   <= '0;
        end else begin
            o_rsp_valid  <= next_rsp_valid;
            o_rsp_target <= next_rsp_target;
            o_rsp_addr   <= next_rsp_addr;
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    sequence s_req;
        i_req_valid;
    endsequence

    sequence s_cpu_high_smram_segment_smm;
        i_req_valid && high_smram_segment_hit && (i_req_src == SRC_CPU) && i_req_smm;
    endsequence

    sequence s_cpu_smram_plain;
        i_req_valid && (high_smram_segment_hit || top_smram_segment_hit)
        && (i_req_src == SRC_CPU) && !i_req_smm && !i_req_wb;
    endsequence

    a_valid_follows: assert property (           // RULE1
        s_req |=> o_rsp_valid)
        else $error("Request not answered one cycle later");

    a_dram_main: assert property (               // RULE1
        (i_req_valid && !high_smram_segment_hit && !top_smram_segment_hit && !hole_hit
         && i_req_addr >= EXT_BASE && addr_w < tom_w)
        |=> (o_rsp_target == TGT_DRAM))
        else $error("Main memory access not routed to DRAM");

    a_hole_hub: assert property (                // RULE2
        (i_req_valid && i_fixed_hole_control && !high_smram_segment_hit && !top_smram_segment_hit
         && in_range(i_req_addr, HOLE_LO, HOLE_HI))
        |=> (o_rsp_target == TGT_HUB))
        else $error("Open hole access reached DRAM");

    a_high_smram_segment_remap: assert property (              // RULE5
        s_cpu_high_smram_segment_smm |=> (o_rsp_target == TGT_DRAM)
        && (o_rsp_addr == (VGA_BASE | ($past(i_req_addr) & HIGH_SMRAM_SEGMENT_MASK))))
        else $error("SMM high segment access not folded to video range");

    a_smram_abort: assert property (             // RULE6
        s_cpu_smram_plain |=> (o_rsp_target == TGT_ABORT))
        else $error("Non-SMM SMRAM access not aborted");

    a_high_smram_segment_hidden: assert property (             // RULE7
        (o_rsp_valid && o_rsp_target == TGT_DRAM)
        |-> !in_range(o_rsp_addr, P_HIGH_SMRAM_SEGMENT_BASE, P_HIGH_SMRAM_SEGMENT_BASE | HIGH_SMRAM_SEGMENT_MASK))
        else $error("DRAM reached at high segment address");

    a_top_smram_segment_same: assert property (               // RULE8
        (i_req_valid && top_smram_segment_hit && !high_smram_segment_hit && (i_req_src == SRC_CPU)
         && i_req_smm) |=> (o_rsp_target == TGT_DRAM)
        && (o_rsp_addr == $past(i_req_addr)))
        else $error("SMM top segment access translated");

    a_smram_foreign: assert property (           // RULE10
        (i_req_valid && (high_smram_segment_hit || top_smram_segment_hit) && (i_req_src != SRC_CPU))
        |=> (o_rsp_target == TGT_HUB))
        else $error("Peer cycle reached SMRAM");

    a_apic_not_agp: assert property (            // RULE13
        (i_req_valid && in_range(i_req_addr, IOAPIC_LO, BIOS_HI))
        |=> (o_rsp_target != TGT_AGP))
        else $error("Fixed hub range routed to AGP");

    a_agp_gate: assert property (                // RULE18
        (i_req_valid && !i_agp_mem_enable) |=> (o_rsp_target != TGT_AGP))
        else $error("AGP claimed with memory enable clear");

    // Above the top of memory, clear of SMRAM and of the hole
    sequence s_above_top;
        i_req_valid && !high_smram_segment_hit && !top_smram_segment_hit && !hole_hit
        && (addr_w >= tom_w);
    endsequence

    a_impedance_compensation_claim: assert property (             // RULE12
        s_above_top ##0 ((i_req_addr & ~IMPEDANCE_COMPENSATION_MASK) == P_IMPEDANCE_COMPENSATION_BASE)
        |=> (o_rsp_target == TGT_MMIO))
        else $error("Compensation window not claimed");

    a_default_hub: assert property (             // RULE12
        s_above_top ##0 (!impedance_compensation_hit && !i_agp_mem_enable)
        |=> (o_rsp_target == TGT_HUB))
        else $error("Space above top not sent to hub link");

    a_ioapic_hub: assert property (              // RULE13
        s_above_top ##0 (!impedance_compensation_hit
                         && in_range(i_req_addr, IOAPIC_LO, IOAPIC_HI))
        |=> (o_rsp_target == TGT_HUB))
        else $error("Interrupt controller range not sent to hub link");

    a_mid_hub: assert property (                 // RULE14
        s_above_top ##0 (!impedance_compensation_hit
                         && in_range(i_req_addr, MID_LO, MID_HI))
        |=> (o_rsp_target == TGT_HUB))
        else $error("Middle range not sent to hub link");

    a_bios_hub: assert property (                // RULE15
        s_above_top ##0 (!impedance_compensation_hit
                         && in_range(i_req_addr, BIOS_LO, BIOS_HI))
        |=> (o_rsp_target == TGT_HUB))
        else $error("Boot range not sent to hub link");

    a_agp_claim: assert property (               // RULE17
        s_above_top ##0 (!impedance_compensation_hit && i_agp_mem_enable
        && (i_req_addr < IOAPIC_LO)
        && (i_req_addr[ADDR_W-1:LOW_W] >= i_agp_window_base)
        && (i_req_addr[ADDR_W-1:LOW_W] <= i_agp_window_limit))
        |=> (o_rsp_target == TGT_AGP))
        else $error("Ordinary window not claimed for AGP");

    a_pref_claim: assert property (              // RULE17
        s_above_top ##0 (!impedance_compensation_hit && i_agp_mem_enable
        && (i_req_addr < IOAPIC_LO)
        && (i_req_addr[ADDR_W-1:LOW_W] >= i_agp_prefetch_window_base)
        && (i_req_addr[ADDR_W-1:LOW_W] <= i_agp_prefetch_window_limit))
        |=> (o_rsp_target == TGT_AGP))
        else $error("Prefetch window not claimed for AGP");

    a_high_smram_segment_wb: assert property (                 // RULE6
        (i_req_valid && high_smram_segment_hit && (i_req_src == SRC_CPU) && !i_req_smm
         && i_req_wb) |=> (o_rsp_target == TGT_DRAM)
        && (o_rsp_addr == (VGA_BASE | ($past(i_req_addr) & HIGH_SMRAM_SEGMENT_MASK))))
        else $error("High segment write-back not redirected");

    a_top_smram_segment_wb: assert property (                 // RULE9
        (i_req_valid && top_smram_segment_hit && !high_smram_segment_hit && (i_req_src == SRC_CPU)
         && !i_req_smm && i_req_wb) |=> (o_rsp_target == TGT_DRAM)
        && (o_rsp_addr == $past(i_req_addr)))
        else $error("Top segment write-back not sent to DRAM");
endmodule
`default_nettype wire

// ---- verif/emad_host_model.sv ----
/* Host processor model issuing memory cycles to the decoder.
   Assumes the bench calls its tasks at the falling clock edge. */
`timescale 1ns/1ns
`default_nettype none
module emad_host_model
    import emad_pkg::*;
(
    // Request to decoder
    output logic              o_req_valid,
    output logic [ADDR_W-1:0] o_req_addr,
    output logic [1:0]        o_req_src,
    output logic              o_req_smm,
    output logic              o_req_wb
);
    // Idle bus at time zero
    initial begin
        o_req_valid = 1'b0;
        o_req_addr  = 32'h5a5a_a5a5;
        o_req_src   = SRC_CPU;
        o_req_smm   = 1'b0;
        o_req_wb    = 1'b0;
    end
    // Present one cycle, held until the next call
    task automatic put(input logic [ADDR_W-1:0] a, input logic [1:0] s,
                       input logic m, input logic w);
        o_req_valid = 1'b1;
        o_req_addr  = a;
        o_req_src   = s;
        o_req_smm   = m;
        o_req_wb    = w;
    endtask
    // Released qualifiers stop showing the last cycle
    task automatic rest();
        o_req_valid = 1'b0;
        o_req_addr  = ~o_req_addr;
        o_req_smm   = ~o_req_smm;
        o_req_wb    = ~o_req_wb;
    endtask
endmodule
`default_nettype wire

// ---- verif/extended_memory_address_decoder_tb.sv ----
/* Self-checking bench for the extended memory address decoder.
   Assumes configuration only changes while no request is presented. */
`timescale 1ns/1ns
`default_nettype none
module extended_memory_address_decoder_tb;
    import emad_pkg::*;
    // ==========================================================
    // Signals
    // ==========================================================
    // High segment kept clear of DRAM, top segment and windows
    localparam logic [ADDR_W-1:0] HIGH_SMRAM_SEGMENT_B  = 32'h0004_0000;
    localparam logic [ADDR_W-1:0] IMPEDANCE_COMPENSATION_B = 32'hfd00_0000;
    logic              clk, resetn, hole, hen, ten, agp_en;
    logic              req_valid, req_smm, req_wb, rsp_valid;
    logic [1:0]        req_src, size;
    logic [2:0]        rsp_target;
    logic [TOM_W-1:0]  tom;
    logic [MB_W-1:0]   b0, l0, b1, l1;
    logic [ADDR_W-1:0] req_addr, rsp_addr;
    int                fail_count, checked, seed;
    // ==========================================================
    // Instances
    // ==========================================================
    emad_host_model host (.o_req_valid(req_valid), .o_req_addr(req_addr),
        .o_req_src(req_src), .o_req_smm(req_smm), .o_req_wb(req_wb));
    emad_decoder #(.P_HIGH_SMRAM_SEGMENT_BASE(HIGH_SMRAM_SEGMENT_B), .P_IMPEDANCE_COMPENSATION_BASE(IMPEDANCE_COMPENSATION_B)) u_dut (
        .i_clk_sys(clk), .i_resetn(resetn), .i_req_valid(req_valid),
        .i_req_addr(req_addr), .i_req_src(req_src), .i_req_smm(req_smm),
        .i_req_wb(req_wb), .i_top_of_main_memory(tom),
        .i_fixed_hole_control(hole), .i_high_smram_segment_en(hen),
        .i_top_smram_segment_en(ten), .i_smram_size_field(size),
        .i_agp_window_base(b0), .i_agp_window_limit(l0),
        .i_agp_prefetch_window_base(b1), .i_agp_prefetch_window_limit(l1),
        .i_agp_mem_enable(agp_en), .o_rsp_valid(rsp_valid),
        .o_rsp_target(rsp_target), .o_rsp_addr(rsp_addr));
    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========================================================
    // Compare tasks
    // ==========================================================
    task automatic chk_bit(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk_tgt(input logic [2:0] e, input logic [2:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch rsp_target expected %h seen %h", e, g);
        end
    endtask
    task automatic chk_addr(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch rsp_addr expected %h seen %h", e, g);
        end
    endtask
    // Expected route from the current configuration
    function automatic void exp_route(input logic [31:0] a,
        input logic [1:0] s, input logic m, input logic w,
        output logic [2:0] t, output logic [31:0] ea);
        logic [32:0] top, sz, wa;
        logic        hs, ts;
        top = {20'h0_0000, (tom > TOM_MAX) ? TOM_MAX : tom} << 20;
        sz  = TOP_SMRAM_SEGMENT_MIN << size;
        wa  = {1'b0, a};
        hs  = hen && a >= HIGH_SMRAM_SEGMENT_B && wa < {1'b0, HIGH_SMRAM_SEGMENT_B} + 33'h2_0000;
        ts  = ten && top >= sz && wa >= top - sz && wa < top;
        ea  = a;
        t   = TGT_HUB;
        if (hs || ts) begin
            if (s != SRC_CPU) t = TGT_HUB;
            else if (!(m || w)) t = TGT_ABORT;
            else begin
                t = TGT_DRAM;
                if (hs) ea = VGA_BASE | (a & HIGH_SMRAM_SEGMENT_MASK);
            end
        end
        else if (hole && a >= HOLE_LO && a <= HOLE_HI) t = TGT_HUB;
        else if (a >= EXT_BASE && wa < top) t = TGT_DRAM;
        else if ((a & ~IMPEDANCE_COMPENSATION_MASK) == IMPEDANCE_COMPENSATION_B) t = TGT_MMIO;
        else if (a >= IOAPIC_LO) t = TGT_HUB;
        else if (agp_en && ((a >= {b0, BASE_LOW} && a <= {l0, LIMIT_LOW}) ||
                 (a >= {b1, BASE_LOW} && a <= {l1, LIMIT_LOW})))
            t = TGT_AGP;
    endfunction
    // One request, answered one cycle later
    task automatic do_req(input logic [31:0] a, input logic [1:0] s,
                          input logic m, input logic w);
        logic [2:0]  t;
        logic [31:0] ea;
        exp_route(a, s, m, w, t, ea);
        host.put(a, s, m, w);
        @(negedge clk);
        chk_bit("rsp_valid", 1'b1, rsp_valid);
        chk_tgt(t, rsp_target);
        if (t != TGT_ABORT) chk_addr(ea, rsp_addr);
    endtask
    // Random configuration; software keeps it static while busy
    task automatic set_cfg(input int i);
        tom    = 13'($urandom_range(16, 4200));
        hole   = 1'($urandom);
        hen    = 1'($urandom);
        ten    = 1'($urandom);
        agp_en = 1'($urandom);
        size   = 2'(i);
        b0     = 12'($urandom_range(12'h800, 12'hfd0));
        l0     = b0 + 12'($urandom_range(0, 15));
        b1     = 12'($urandom_range(12'h800, 12'hfd0));
        l1     = b1 + 12'($urandom_range(0, 15));
        if (i < 2) begin
            tom  = (i == 0) ? 13'h1fff : 13'h1000;
            hen  = 1'b1;
            ten  = 1'b1;
            hole = 1'(i);
        end
    endtask
    // Corner and random addresses back to back
    task automatic run_set();
        logic [31:0] top, sz;
        logic [31:0] q[$];
        top = ((tom > TOM_MAX) ? 32'h0 : {tom[11:0], 20'h0_0000});
        sz  = 32'h2_0000 << size;
        q = '{EXT_BASE - 1, EXT_BASE, HOLE_LO - 1, HOLE_LO, HOLE_HI,
              HOLE_HI + 1, HIGH_SMRAM_SEGMENT_B, HIGH_SMRAM_SEGMENT_B + 32'h1_ffff, HIGH_SMRAM_SEGMENT_B + 32'h2_0000,
              IMPEDANCE_COMPENSATION_B, IMPEDANCE_COMPENSATION_B + 32'hfff, IMPEDANCE_COMPENSATION_B + 32'h1000, IOAPIC_LO - 1,
              32'hfec0_f000, MID_LO, MID_HI, BIOS_LO, BIOS_HI, VGA_BASE,
              {b0, BASE_LOW}, {l0, LIMIT_LOW}, {b1, BASE_LOW} - 1,
              {l1, LIMIT_LOW} + 1, top - 1, top, top - sz, top - sz - 1};
        repeat (12) q.push_back(top - $urandom_range(0, 32'h40_0000));
        repeat (12) q.push_back($urandom);
        for (int c = 0; c < 4; c++) begin
            do_req(HIGH_SMRAM_SEGMENT_B + 32'h40, SRC_CPU, c[1], c[0]);
            do_req(top - 32'h40, SRC_CPU, c[1], c[0]);
        end
        foreach (q[k])
            do_req(q[k], 2'($urandom_range(0, 2)), 1'($urandom), 1'($urandom));
        host.rest();
        @(negedge clk);
        chk_bit("rsp_valid idle", 1'b0, rsp_valid);
    endtask
    // Verdict and end of run
    task automatic finish_test();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        seed = $urandom(32'h7a08d488);
        fail_count = 0;
        checked = 0;
        resetn = 1'b0;
        set_cfg(0);
        repeat (6) @(negedge clk);
        chk_bit("rsp_valid reset", 1'b0, rsp_valid);
        chk_tgt(TGT_HUB, rsp_target);
        resetn = 1'b1;
        for (int i = 0; i < 12; i++) begin
            set_cfg(i % 4);
            @(negedge clk);
            run_set();
        end
        // Reset in mid-stream swallows the pending request
        host.put(EXT_BASE, SRC_CPU, 1'b0, 1'b0);
        resetn = 1'b0;
        @(negedge clk);
        chk_bit("rsp_valid mid reset", 1'b0, rsp_valid);
        chk_addr(32'h0, rsp_addr);
        host.rest();
        resetn = 1'b1;
        @(negedge clk);
        do_req(EXT_BASE, SRC_CPU, 1'b0, 1'b0);
        finish_test();
    end
    // Hang guard
    initial begin
        #500000;
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire
